/* rtl/css_pkg.sv */
// Purpose: shared constants and types of the command sync block
// Assumes: 32-bit register port, byte offsets on 8-bit address
// Notes: raw status holds seven bits, upper bits read zero
package css_pkg;

////////////////////////////////////////////////////////////////////////////
// register offsets
localparam logic [7:0] OFS_PARSER_MODE = 8'h00;
localparam logic [7:0] OFS_STATUS_WMASK = 8'h04;
localparam logic [7:0] OFS_RAW_STATUS = 8'h08;
localparam logic [7:0] OFS_IDENTITY = 8'h0C;
localparam logic [7:0] OFS_REPORT_MASK = 8'h10;
localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
localparam logic [7:0] OFS_ERR_MASK = 8'h18;

////////////////////////////////////////////////////////////////////////////
// field positions and widths
localparam int ST_W = 7;
localparam int ERR_W = 8;
localparam int NPLANE = 2;
localparam int PM_SYNC = 0;
localparam int ST_ERR = 0;
localparam int ST_THERM = 1;
localparam int ST_SYNC = 2;
localparam int ST_FLIP0 = 3;
localparam int ST_VBL0 = 5;
localparam logic [ST_W-1:0] FLIP_BITS = 7'h18;
localparam logic [31:0] HWS_DWORD = 32'h00000000;

////////////////////////////////////////////////////////////////////////////
// reset values
localparam logic [ST_W-1:0] WMASK_RST = 7'h7F;
localparam logic [ST_W-1:0] RMASK_RST = 7'h7F;
localparam logic [ST_W-1:0] IER_RST = 7'h00;
localparam logic [ERR_W-1:0] EMASK_RST = 8'hFF;

////////////////////////////////////////////////////////////////////////////
// types
typedef enum logic [2:0] {
    CMD_OTHER = 3'b000,
    CMD_FLUSH = 3'b001,
    CMD_FLIP = 3'b010,
    CMD_STORE = 3'b011,
    CMD_BATCH = 3'b100,
    CMD_REPORT = 3'b101
} css_cmd_e;

typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FLUSH = 3'b001,
    S_CLR = 3'b010,
    S_TOG = 3'b011,
    S_ACK = 3'b100
} css_state_e;

typedef struct packed {
    logic valid;
    css_cmd_e kind;
    logic plane;
} css_cmd_s;

typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
} css_bus_s;

typedef struct packed {
    logic valid;
    logic [31:0] dword;
    logic [31:0] data;
} css_hws_s;

endpackage

/* rtl/css_pin_sync.sv */
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: one clock, asynchronous active-low reset
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module css_pin_sync #(
    parameter int W = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_pin,
    output var logic [W-1:0] o_level
);

////////////////////////////////////////////////////////////////////////////
// per-bit chain
genvar g;
generate
    for (g = 0; g < W; g++) begin : g_bit
        logic [2:0] s_reg;
        logic lvl_reg;
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                s_reg <= 3'h0;
                lvl_reg <= 1'b0;
            end else begin
                s_reg <= {s_reg[1:0], i_pin[g]};
                if (s_reg[1] == s_reg[2]) begin
                    lvl_reg <= s_reg[2];
                end
            end
        end
        assign o_level[g] = lvl_reg;
    end
endgenerate

endmodule
`default_nettype wire

/* rtl/css_cmd_sync.sv */
// Purpose: parser sync, on-demand flush and raw status bits
// Assumes: command source holds valid until ack, plain register port
// Notes: vblank and thermal arrive from pins and are synchronised
`timescale 1ns/100ps
`default_nettype none
module css_cmd_sync
    import css_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire css_bus_s i_bus,
    output var logic [31:0] o_rdata,
    input wire css_cmd_s i_cmd,
    output var logic o_cmd_ack,
    input wire logic i_mi_busy,
    output var logic o_flush_req,
    input wire logic i_engines_idle,
    input wire logic i_cache_done,
    input wire logic [ERR_W-1:0] i_err,
    input wire logic i_thermal_pin,
    input wire logic [NPLANE-1:0] i_vblank_pin,
    output var logic [NPLANE-1:0] o_flip_done,
    output var css_hws_s o_hws,
    input wire logic i_hws_ready,
    output var logic o_irq
);

typedef struct packed {
    css_state_e st;
    logic is_sync;
    logic ack;
    logic flush_req;
    logic sync_en;
    logic [ST_W-1:0] wmask;
    logic [ST_W-1:0] rmask;
    logic [ST_W-1:0] irq_enable_mask;
    logic [ERR_W-1:0] emask;
    logic [ST_W-1:0] raw;
    logic [ST_W-1:0] ident;
    logic [NPLANE-1:0] vbl_d;
    logic [NPLANE-1:0] flip_done;
    css_hws_s hws;
    logic [31:0] rdata;
    logic irq;
} css_regs_s;

css_regs_s q_reg;
css_regs_s q_next;
logic [NPLANE:0] pin_level;
logic [NPLANE-1:0] vbl_s;
logic therm_s;
logic take;
logic flush_ok;
logic [NPLANE-1:0] vbl_rise;

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
css_pin_sync #(.W(NPLANE + 1)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin({i_thermal_pin, i_vblank_pin}),
    .o_level(pin_level)
);
assign vbl_s = pin_level[NPLANE-1:0];
assign therm_s = pin_level[NPLANE];
assign vbl_rise = vbl_s & ~q_reg.vbl_d;
assign flush_ok = i_engines_idle & i_cache_done;
assign take = (q_reg.st == S_IDLE) & ~q_reg.sync_en & i_cmd.valid
    & ~i_mi_busy;

////////////////////////////////////////////////////////////////////////////
// next state
always_comb begin
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;
    ev = '0;
    w1c = '0;
    q_next = q_reg;
    q_next.ack = 1'b0;
    q_next.flip_done = '0;
    q_next.vbl_d = vbl_s;
    q_next.rdata = 32'h00000000;
    // parser sequence
    case (q_reg.st)
        S_IDLE: begin
            if (q_reg.sync_en) begin
                q_next.st = S_FLUSH;
                q_next.is_sync = 1'b1;
                q_next.flush_req = 1'b1;
            end else if (take && i_cmd.kind == CMD_FLUSH) begin
                q_next.st = S_FLUSH;
                q_next.is_sync = 1'b0;
                q_next.flush_req = 1'b1;
            end else if (take) begin
                // flips, stores, reports, batches retire on the next cycle
                q_next.st = S_ACK;
                q_next.ack = 1'b1;
            end
        end
        S_FLUSH: begin
            // store and flip completion is not waited on
            if (flush_ok) begin
                q_next.flush_req = 1'b0;
                if (q_reg.is_sync) begin
                    q_next.st = S_CLR;
                end else begin
                    q_next.st = S_ACK;
                    q_next.ack = 1'b1;
                end
            end
        end
        S_CLR: begin
            q_next.sync_en = 1'b0;
            q_next.st = S_TOG;
        end
        S_TOG: begin
            q_next.st = S_IDLE;
        end
        S_ACK: begin
            q_next.st = S_IDLE;
        end
        default: begin
            q_next.st = S_IDLE;
        end
    endcase
    // register writes
    if (i_bus.wr) begin
        case (i_bus.addr)
            OFS_PARSER_MODE: begin
                if (i_bus.wdata[PM_SYNC]) begin
                    q_next.sync_en = 1'b1;
                end
            end
            OFS_STATUS_WMASK: q_next.wmask = i_bus.wdata[ST_W-1:0];
            OFS_IDENTITY: w1c = i_bus.wdata[ST_W-1:0];
            OFS_REPORT_MASK: q_next.rmask = i_bus.wdata[ST_W-1:0];
            OFS_IRQ_ENABLE: q_next.irq_enable_mask = i_bus.wdata[ST_W-1:0];
            OFS_ERR_MASK: q_next.emask = i_bus.wdata[ERR_W-1:0];
            default: ;
        endcase
    end
    // raw status bits
    q_next.raw[ST_ERR] = |(i_err & ~q_reg.emask);
    q_next.raw[ST_THERM] = therm_s;
    if (q_reg.st == S_TOG) begin
        q_next.raw[ST_SYNC] = ~q_reg.raw[ST_SYNC];
    end
    for (int p = 0; p < NPLANE; p++) begin
        if (vbl_rise[p]) begin
            q_next.raw[ST_VBL0 + p] = 1'b1;
            if (q_reg.raw[ST_FLIP0 + p]) begin
                q_next.raw[ST_FLIP0 + p] = 1'b0;
                q_next.flip_done[p] = 1'b1;
            end
        end else if (!vbl_s[p]) begin
            q_next.raw[ST_VBL0 + p] = 1'b0;
        end
        if (take && i_cmd.kind == CMD_FLIP && i_cmd.plane == p[0]) begin
            q_next.raw[ST_FLIP0 + p] = 1'b1;
        end
    end
    // identity: flips on falling edge, others on rising
    ev = (q_next.raw & ~q_reg.raw & ~FLIP_BITS)
        | (~q_next.raw & q_reg.raw & FLIP_BITS);
    q_next.ident = (q_reg.ident & ~w1c) | (ev & ~q_reg.rmask);
    q_next.irq = |(q_next.ident & q_next.irq_enable_mask);
    // status page write
    if (q_reg.hws.valid && i_hws_ready) begin
        q_next.hws.valid = 1'b0;
    end
    if (|((q_next.raw ^ q_reg.raw) & ~q_reg.wmask)) begin
        q_next.hws.valid = 1'b1;
        q_next.hws.dword = HWS_DWORD;
        q_next.hws.data = {{(32-ST_W){1'b0}}, q_next.raw};
    end
    // read data, one cycle later
    if (i_bus.rd) begin
        case (i_bus.addr)
            OFS_PARSER_MODE: q_next.rdata[PM_SYNC] = q_reg.sync_en;
            OFS_STATUS_WMASK: q_next.rdata[ST_W-1:0] = q_reg.wmask;
            OFS_RAW_STATUS: q_next.rdata[ST_W-1:0] = q_reg.raw;
            OFS_IDENTITY: q_next.rdata[ST_W-1:0] = q_reg.ident;
            OFS_REPORT_MASK: q_next.rdata[ST_W-1:0] = q_reg.rmask;
            OFS_IRQ_ENABLE: q_next.rdata[ST_W-1:0] = q_reg.irq_enable_mask;
            OFS_ERR_MASK: q_next.rdata[ERR_W-1:0] = q_reg.emask;
            default: q_next.rdata = 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// state register
always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        q_reg <= '0;
        q_reg.st <= S_IDLE;
        q_reg.wmask <= WMASK_RST;
        q_reg.rmask <= RMASK_RST;
        q_reg.irq_enable_mask <= IER_RST;
        q_reg.emask <= EMASK_RST;
    end else begin
        q_reg <= q_next;
    end
end

assign o_rdata = q_reg.rdata;
assign o_cmd_ack = q_reg.ack;
assign o_flush_req = q_reg.flush_req;
assign o_flip_done = q_reg.flip_done;
assign o_hws = q_reg.hws;
assign o_irq = q_reg.irq;

////////////////////////////////////////////////////////////////////////////
// assertions
property p_accept_ready;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_cmd_ack) && $past(q_reg.st) == S_IDLE |-> !$past(i_mi_busy);
endproperty
a_accept_ready: assert property (p_accept_ready)
    else $error("command taken while earlier command busy");

property p_flush_stall;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_FLUSH && !flush_ok |=> q_reg.st == S_FLUSH && !o_cmd_ack;
endproperty
a_flush_stall: assert property (p_flush_stall)
    else $error("flush left before engines idle");

property p_flush_adv;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_FLUSH && flush_ok && !q_reg.is_sync
        |=> o_cmd_ack && !o_flush_req ##1 !o_cmd_ack;
endproperty
a_flush_adv: assert property (p_flush_adv)
    else $error("flush did not advance to next command");

property p_sync_take;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_IDLE && q_reg.sync_en
        |=> q_reg.st == S_FLUSH && o_flush_req && !o_cmd_ack;
endproperty
a_sync_take: assert property (p_sync_take)
    else $error("flush request not taken while idle");

property p_sync_order;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_CLR
        |=> !q_reg.sync_en ##1 q_reg.raw[ST_SYNC] != $past(q_reg.raw[ST_SYNC]);
endproperty
a_sync_order: assert property (p_sync_order)
    else $error("request bit not cleared before toggle");

property p_hws_launch;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(q_reg.raw[ST_SYNC]) && !$past(q_reg.wmask[ST_SYNC])
        |-> o_hws.valid && o_hws.data[ST_SYNC] == q_reg.raw[ST_SYNC]
        && o_hws.dword == HWS_DWORD;
endproperty
a_hws_launch: assert property (p_hws_launch)
    else $error("toggle did not launch status page write");

property p_hws_any;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    |(($past(q_reg.raw) ^ q_reg.raw) & ~$past(q_reg.wmask)) |-> o_hws.valid;
endproperty
a_hws_any: assert property (p_hws_any)
    else $error("unmasked status change without write");

property p_err_bit;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 q_reg.raw[ST_ERR] == |($past(i_err) & ~$past(q_reg.emask));
endproperty
a_err_bit: assert property (p_err_bit)
    else $error("error bit does not follow unmasked errors");

property p_flip_set;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    take && i_cmd.kind == CMD_FLIP && !i_cmd.plane
        |=> q_reg.raw[ST_FLIP0] && o_cmd_ack;
endproperty
a_flip_set: assert property (p_flip_set)
    else $error("flip command did not set pending");

property p_flip_clr;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.raw[ST_FLIP0] && vbl_rise[0]
        |=> !q_reg.raw[ST_FLIP0] && o_flip_done[0] ##1 !o_flip_done[0];
endproperty
a_flip_clr: assert property (p_flip_clr)
    else $error("vblank did not perform pending flip");

property p_flip_ident;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    $fell(q_reg.raw[ST_FLIP0]) && !$past(q_reg.rmask[ST_FLIP0])
        |-> q_reg.ident[ST_FLIP0];
endproperty
a_flip_ident: assert property (p_flip_ident)
    else $error("falling flip pending missed identity");

property p_vbl_set;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    vbl_rise[1] |=> q_reg.raw[ST_VBL0 + 1];
endproperty
a_vbl_set: assert property (p_vbl_set)
    else $error("vblank leading edge did not set status");

property p_irq;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    o_irq == |(q_reg.ident & q_reg.irq_enable_mask);
endproperty
a_irq: assert property (p_irq)
    else $error("interrupt not gated by enabled identity");

c_sync_flush: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_TOG ##1 o_hws.valid);
c_full_flush: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    q_reg.st == S_FLUSH && !q_reg.is_sync ##[1:20] o_cmd_ack);
c_flip_cycle: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(q_reg.raw[ST_FLIP0]) ##[1:200] o_flip_done[0]);

endmodule
`default_nettype wire

/* tb/css_host_mem.sv */
// Purpose: status page memory written by the block
// Assumes: write request held until ready seen
// Notes: slow mode grants one write in four cycles
`timescale 1ns/100ps
`default_nettype none
module css_host_mem
    import css_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire css_hws_s i_hws,
    input wire logic i_slow,
    output var logic o_ready,
    output var logic [31:0] o_dword0,
    output var logic [7:0] o_wr_cnt
);
    logic [1:0] ph_reg;
    assign o_ready = !i_slow || (ph_reg == 2'h3);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ph_reg <= 2'h0;
            o_dword0 <= 32'h0;
            o_wr_cnt <= 8'h0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            if (i_hws.valid && o_ready) begin
                if (i_hws.dword == HWS_DWORD) begin
                    o_dword0 <= i_hws.data;
                end
                o_wr_cnt <= o_wr_cnt + 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_css_cmd_sync.sv */
// Purpose: self-checking bench of the command sync block
// Assumes: 40 MHz clock, bus driven at rising edge
// Notes: status page modelled by css_host_mem
`timescale 1ns/100ps
`default_nettype none
module tb_css_cmd_sync;
    import css_pkg::*;
    logic clk, rst_n, busy, idle, cdone, therm, ack, freq, irq, slow, hrdy;
    logic [1:0] vbl, fdone;
    logic [7:0] err, wcnt;
    logic [31:0] rdata, dw0, saved;
    css_bus_s bus;
    css_cmd_s cmd_r;
    css_hws_s hws;
    int fails, n_checks, n_ack;
    css_cmd_e kinds[4] = '{CMD_STORE, CMD_BATCH, CMD_REPORT, CMD_OTHER};

    css_cmd_sync css_cmd_sync_i (.i_sys_clk(clk), .i_arst_n(rst_n),
        .i_bus(bus), .o_rdata(rdata), .i_cmd(cmd_r), .o_cmd_ack(ack),
        .i_mi_busy(busy), .o_flush_req(freq), .i_engines_idle(idle),
        .i_cache_done(cdone), .i_err(err), .i_thermal_pin(therm),
        .i_vblank_pin(vbl), .o_flip_done(fdone), .o_hws(hws),
        .i_hws_ready(hrdy), .o_irq(irq));
    css_host_mem css_host_mem_i (.i_sys_clk(clk), .i_arst_n(rst_n),
        .i_hws(hws), .i_slow(slow), .o_ready(hrdy), .o_dword0(dw0),
        .o_wr_cnt(wcnt));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task cmd(input css_cmd_e k, input logic p);
        n_ack = 0;
        @(posedge clk);
        cmd_r <= '{valid: 1'b1, kind: k, plane: p};
        do begin
            @(posedge clk);
            #1 n_ack++;
        end while (ack !== 1'b1 && n_ack < 50);
        @(posedge clk);
        cmd_r.valid <= 1'b0;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, reset, watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        bus = '0;
        cmd_r = '0;
        {busy, idle, cdone, therm, slow} = 5'h0;
        vbl = 2'h0;
        err = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_STATUS_WMASK, 32'h7F);
        rd(OFS_REPORT_MASK, 32'h7F);
        rd(OFS_IRQ_ENABLE, 32'h0);
        rd(OFS_ERR_MASK, 32'hFF);
        rd(8'h1C, 32'h0);
        wr(OFS_RAW_STATUS, 32'hFF);
        rd(OFS_RAW_STATUS, 32'h0);
        wr(OFS_STATUS_WMASK, 32'h62);
        rd(OFS_STATUS_WMASK, 32'h62);
        wr(OFS_REPORT_MASK, 32'h77);
        wr(OFS_IRQ_ENABLE, 32'h08);
        // held until earlier memory work completes
        @(posedge clk);
        busy <= 1'b1;
        fork
            cmd(CMD_OTHER, 1'b0);
            begin
                repeat (5) @(posedge clk);
                busy <= 1'b0;
            end
        join
        check(32'(n_ack), 32'h5);
        foreach (kinds[i]) begin
            cmd(kinds[i], 1'b0);
            check(32'(n_ack), 32'h1);
        end
        // flip, then vertical blank performs it
        cmd(CMD_FLIP, 1'b0);
        check(32'(n_ack), 32'h1);
        rd(OFS_RAW_STATUS, 32'h08);
        check(dw0, 32'h08);
        @(posedge clk);
        vbl <= 2'b01;
        for (int i = 0; i < 10 && fdone[0] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(32'(fdone), 32'h1);
        rd(OFS_RAW_STATUS, 32'h20);
        rd(OFS_IDENTITY, 32'h08);
        check(32'(irq), 32'h1);
        wr(OFS_IDENTITY, 32'h08);
        vbl <= 2'b00;
        repeat (6) @(posedge clk);
        #1 check(32'(irq), 32'h0);
        rd(OFS_RAW_STATUS, 32'h0);
        check(dw0, 32'h20);
        // full flush stalls the parser, flips left pending
        cmd(CMD_FLIP, 1'b1);
        fork
            cmd(CMD_FLUSH, 1'b0);
            begin
                repeat (8) @(posedge clk);
                #1 check({freq, ack}, 32'h2);
                @(posedge clk);
                idle <= 1'b1;
                cdone <= 1'b1;
            end
        join
        check(32'(n_ack), 32'h9);
        check(32'(freq), 32'h0);
        rd(OFS_RAW_STATUS, 32'h10);
        vbl <= 2'b10;
        for (int i = 0; i < 10 && fdone[1] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(32'(fdone), 32'h2);
        repeat (8) @(posedge clk);
        check(dw0, 32'h40);
        rd(OFS_IDENTITY, 32'h0);
        vbl <= 2'b00;
        repeat (8) @(posedge clk);
        // error sources through the mask
        wr(OFS_ERR_MASK, 32'hFE);
        err <= 8'h02;
        rd(OFS_RAW_STATUS, 32'h0);
        err <= 8'h03;
        repeat (3) @(posedge clk);
        rd(OFS_RAW_STATUS, 32'h1);
        check(dw0, 32'h1);
        err <= 8'h00;
        repeat (3) @(posedge clk);
        w_chk: begin
            logic [7:0] w0;
            w0 = wcnt;
            saved = dw0;
            check(dw0, 32'h0);
            therm <= 1'b1;
            repeat (8) @(posedge clk);
            rd(OFS_RAW_STATUS, 32'h2);
            check(32'(wcnt), 32'(w0));
        end
        // on-demand flush against a slow status page
        idle <= 1'b0;
        cdone <= 1'b0;
        slow <= 1'b1;
        wr(OFS_PARSER_MODE, 32'h1);
        for (int i = 0; i < 10 && freq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(32'(freq), 32'h1);
        @(posedge clk);
        idle <= 1'b1;
        cdone <= 1'b1;
        for (int i = 0; i < 60 && dw0[ST_SYNC] === saved[ST_SYNC]; i++) begin
            @(posedge clk);
            #1;
        end
        check(32'(dw0[ST_SYNC]), {31'h0, ~saved[ST_SYNC]});
        check(dw0, 32'h6);
        rd(OFS_PARSER_MODE, 32'h0);
        rd(OFS_RAW_STATUS, 32'h6);
        finish_test();
    end
endmodule
`default_nettype wire
